// [inc/hf_osc_pkg.sv]
// Operation
// - after reset the system clock source is the internal high-frequency oscillator
// - divider field 00 divides by 8, 01 by 4, 10 by 2, 11 by 1
// - divider field resets to divide-by-eight
// - writing one to force-suspend stops the oscillator in the run state only
// - suspended oscillator restarts on non-idle usb event or bus power polarity match
// - usb wake events are honoured even while the transceiver is disabled
// - control register resets to 0x80, top bit enables the oscillator
// - system clock source selects hf osc, lf osc, external, or multiplier over two
// - usb clock source selects hf osc, external, or multiplier
// - period trim register resets to a factory value giving 12 MHz
package hf_osc_pkg;

  localparam logic [7:0] ADDR_CONTROL     = 8'hB2;
  localparam logic [7:0] ADDR_TRIM        = 8'hB3;
  localparam logic [7:0] ADDR_CLKSEL      = 8'hC0;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'hC1;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'hC2;

  localparam logic [7:0] CONTROL_RESET    = 8'h80;
  localparam int         BIT_ENABLE       = 7;
  localparam int         BIT_READY        = 6;
  localparam int         BIT_SUSPEND      = 5;
  localparam logic [4:0] TRIM_FACTORY     = 5'h10;
  localparam logic [7:0] CLKSEL_RESET     = 8'h00;
  localparam logic [7:0] IRQ_RESET        = 8'h00;
  localparam logic [7:0] READ_ZERO        = 8'h00;

  localparam int         IRQ_READY        = 0;
  localparam int         IRQ_WAKE         = 1;
  localparam int         IRQ_LOST         = 2;
  localparam logic [2:0] IRQ_BITS_MASK    = 3'h7;

  localparam int         SETTLE_NS        = 2000;
  localparam int         CLK_NS           = 100;
  localparam int         SETTLE_CYCLES    = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] SETTLE_COUNT     = 8'(SETTLE_CYCLES);
  localparam logic [7:0] COUNT_ZERO       = 8'h00;
  localparam logic [7:0] COUNT_ONE        = 8'h01;

  typedef enum logic [1:0] {
    DIV_8 = 2'b00,
    DIV_4 = 2'b01,
    DIV_2 = 2'b10,
    DIV_1 = 2'b11
  } divider_type;

  typedef enum logic [1:0] {
    SYS_HF   = 2'b00,
    SYS_EXT  = 2'b01,
    SYS_MULT = 2'b10,
    SYS_LF   = 2'b11
  } sys_source_type;

  typedef enum logic [1:0] {
    USB_HF   = 2'b00,
    USB_MULT = 2'b01,
    USB_EXT  = 2'b10,
    USB_RSVD = 2'b11
  } usb_source_type;

  typedef enum logic [1:0] {
    OSC_OFF      = 2'b00,
    OSC_SETTLE   = 2'b01,
    OSC_RUN      = 2'b10,
    OSC_SUSPEND  = 2'b11
  } osc_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       write;
    logic       read;
  } bus_req_type;

  typedef struct packed {
    sys_source_type sysSource;
    usb_source_type usbSource;
    divider_type    divider;
  } clock_sel_type;

endpackage

// [verilog/hf_oscillator_clock_control.sv]
`timescale 1ns/10ps
module hf_oscillator_clock_control
  import hf_osc_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           rst,
  input  wire bus_req_type    busReq,
  output logic [7:0]          readData,
  input  wire logic           usbNonIdleEvent,
  input  wire logic           usbTransceiverEnable,
  input  wire logic           busPowerLevel,
  input  wire logic           bus_power_polarity_select,
  output logic                hfOscRun,
  output logic [4:0]          hfOscPeriodTrim,
  output clock_sel_type       clockSel,
  output logic                sysClockEnable,
  output logic                irq
);

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  function automatic logic hit(input bus_req_type r, input logic [7:0] a);
    hit = r.addr == a;
  endfunction

  // last count of the divider for each setting
  function automatic logic [7:0] divMax(input divider_type d);
    case (d)
      DIV_8:   divMax = 8'h07;
      DIV_4:   divMax = 8'h03;
      DIV_2:   divMax = 8'h01;
      DIV_1:   divMax = 8'h00;
      default: divMax = 8'h07;
    endcase
  endfunction

  logic          wrControl;
  logic          wrTrim;
  logic          wrClkSel;
  logic          wrStatus;
  logic          wrMask;
  logic          wakeEvent;

  // ------------------------------------------------------------
  // register write decode
  // ------------------------------------------------------------
  assign wrControl = busReq.write && hit(busReq, ADDR_CONTROL);
  assign wrTrim    = busReq.write && hit(busReq, ADDR_TRIM);
  assign wrClkSel  = busReq.write && hit(busReq, ADDR_CLKSEL);
  assign wrStatus  = busReq.write && hit(busReq, ADDR_IRQ_STATUS);
  assign wrMask    = busReq.write && hit(busReq, ADDR_IRQ_MASK);

  // ------------------------------------------------------------
  // wake detection
  // ------------------------------------------------------------
  // transceiver enable deliberately ignored for wake detection
  assign wakeEvent = usbNonIdleEvent
                     || (busPowerLevel == bus_power_polarity_select);

  // ------------------------------------------------------------
  // registers and oscillator state
  // ------------------------------------------------------------
  logic          enable;
  logic [1:0]    divider;
  logic [4:0]    trim;
  clock_sel_type sel;
  logic [2:0]    status;
  logic [2:0]    mask;
  osc_state_type state;
  logic [7:0]    settle;
  logic [7:0]    divCount;
  logic [7:0]    rdata;
  logic          tick;
  logic          irqLine;

  logic          next_enable;
  logic [1:0]    next_divider;
  logic [4:0]    next_trim;
  clock_sel_type next_sel;
  logic [2:0]    next_status;
  logic [2:0]    next_mask;
  osc_state_type next_state;
  logic [7:0]    next_settle;
  logic [7:0]    next_divCount;
  logic [7:0]    next_rdata;
  logic          next_tick;
  logic          next_irqLine;
  logic          runReg;
  logic          next_runReg;
  logic          ready;
  logic [2:0]    events;

  assign ready = state == OSC_RUN;

  always_comb begin
    next_enable   = enable;
    next_divider  = divider;
    next_trim     = trim;
    next_sel      = sel;
    next_mask     = mask;
    // the divider follows the same control write; bits 4..2 are not stored
    if (wrControl) begin
      next_enable  = busReq.wdata[BIT_ENABLE];
      next_divider = busReq.wdata[1:0];
    end
    if (wrTrim) begin
      next_trim = busReq.wdata[4:0];
    end
    if (wrClkSel) begin
      next_sel = clock_sel_type'(busReq.wdata[5:0]);
    end
    if (wrMask) begin
      next_mask = busReq.wdata[2:0] & IRQ_BITS_MASK;
    end
  end

  // ------------------------------------------------------------
  // oscillator state machine
  // ------------------------------------------------------------
  always_comb begin
    next_state  = state;
    next_settle = settle;
    events      = 3'h0;
    case (state)
      OSC_OFF: begin
        if (next_enable) begin
          next_state  = OSC_SETTLE;
          next_settle = SETTLE_COUNT;
        end
      end
      OSC_SETTLE: begin
        // count down; run follows once the count reaches one
        if (settle == COUNT_ONE || settle == COUNT_ZERO) begin
          next_state = OSC_RUN;
          events[IRQ_READY] = 1'b1;
        end else begin
          next_settle = settle - COUNT_ONE;
        end
      end
      OSC_RUN: begin
        // a suspend write outside the run state is ignored
        if (wrControl && busReq.wdata[BIT_SUSPEND]) begin
          next_state = OSC_SUSPEND;
          events[IRQ_LOST] = 1'b1;
        end
      end
      OSC_SUSPEND: begin
        if (wakeEvent) begin
          next_state  = OSC_SETTLE;
          next_settle = SETTLE_COUNT;
          events[IRQ_WAKE] = 1'b1;
        end
      end
      default: begin
        next_state = OSC_OFF;
      end
    endcase
    // clearing the enable bit stops the oscillator from any state
    if (!next_enable && state != OSC_OFF) begin
      next_state = OSC_OFF;
      if (state == OSC_RUN) begin
        events[IRQ_LOST] = 1'b1;
      end
    end
    next_runReg = next_state == OSC_SETTLE || next_state == OSC_RUN;
  end

  // ------------------------------------------------------------
  // sticky status bits
  // ------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_status
    logic clearBit;
    // set wins over a write-one clear
    assign clearBit       = wrStatus && busReq.wdata[i];
    assign next_status[i] = events[i] || (status[i] && !clearBit);
  end

  // ------------------------------------------------------------
  // system clock divider
  // ------------------------------------------------------------
  always_comb begin
    next_divCount = divCount;
    next_tick     = 1'b0;
    // no tick once the oscillator is leaving the run state
    if (ready && next_state == OSC_RUN) begin
      if (divCount >= divMax(divider_type'(divider))) begin
        next_divCount = COUNT_ZERO;
        next_tick     = 1'b1;
      end else begin
        next_divCount = divCount + COUNT_ONE;
      end
    end else begin
      next_divCount = COUNT_ZERO;
    end
  end

  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------
  always_comb begin
    next_rdata = READ_ZERO;
    if (busReq.read) begin
      // suspend is an action, not a stored bit, so it reads back as zero
      case (busReq.addr)
        ADDR_CONTROL:    next_rdata = {enable, ready, 1'b0, 3'b000, divider};
        ADDR_TRIM:       next_rdata = {3'b000, trim};
        ADDR_CLKSEL:     next_rdata = {2'b00, sel};
        ADDR_IRQ_STATUS: next_rdata = {5'h00, status};
        ADDR_IRQ_MASK:   next_rdata = {5'h00, mask};
        default:         next_rdata = READ_ZERO;
      endcase
    end
  end

  // ------------------------------------------------------------
  // interrupt line
  // ------------------------------------------------------------
  always_comb begin
    next_irqLine = |(next_status & next_mask);
  end

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enable  <= CONTROL_RESET[BIT_ENABLE];
      divider <= CONTROL_RESET[1:0];
      trim    <= TRIM_FACTORY;
      sel     <= clock_sel_type'(CLKSEL_RESET[5:0]);
      mask    <= IRQ_RESET[2:0];
    end else begin
      enable  <= next_enable;
      divider <= next_divider;
      trim    <= next_trim;
      sel     <= next_sel;
      mask    <= next_mask;
    end
  end

  // ------------------------------------------------------------
  // oscillator state registers
  // ------------------------------------------------------------
  // the run output mirrors the settle and run states
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state  <= OSC_OFF;
      settle <= COUNT_ZERO;
      runReg <= 1'b0;
    end else begin
      state  <= next_state;
      settle <= next_settle;
      runReg <= next_runReg;
    end
  end

  // ------------------------------------------------------------
  // status register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status <= IRQ_RESET[2:0];
    end else begin
      status <= next_status;
    end
  end

  // ------------------------------------------------------------
  // divider, read data and interrupt registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      divCount <= COUNT_ZERO;
      rdata    <= READ_ZERO;
      tick     <= 1'b0;
      irqLine  <= 1'b0;
    end else begin
      divCount <= next_divCount;
      rdata    <= next_rdata;
      tick     <= next_tick;
      irqLine  <= next_irqLine;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // every output is a register copy
  assign readData        = rdata;
  assign hfOscRun        = runReg;
  assign hfOscPeriodTrim = trim;
  assign clockSel        = sel;
  assign sysClockEnable  = tick;
  assign irq             = irqLine;
  logic unusedXcvr;
  assign unusedXcvr = usbTransceiverEnable;

endmodule

// [tb/hf_osc_props.sv]
`timescale 1ns/10ps
module hf_osc_props
  import hf_osc_pkg::*;
(
  input wire logic          core_clk,
  input wire logic          rst,
  input wire bus_req_type   busReq,
  input wire logic [7:0]    readData,
  input wire logic          hfOscRun,
  input wire logic [4:0]    hfOscPeriodTrim,
  input wire clock_sel_type clockSel,
  input wire logic          sysClockEnable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // control divider as last written, for the tick spacing check
  divider_type ctrlDivider;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrlDivider <= divider_type'(CONTROL_RESET[1:0]);
    end else if (busReq.write && busReq.addr == ADDR_CONTROL) begin
      ctrlDivider <= divider_type'(busReq.wdata[1:0]);
    end
  end
  a_ctrl_zero_bits: assert property (
    busReq.read && busReq.addr == ADDR_CONTROL |=> readData[5:2] == 4'h0)
    else $error("unused control bits not zero");
  a_disable_stops: assert property (
    busReq.write && busReq.addr == ADDR_CONTROL && !busReq.wdata[BIT_ENABLE]
    |-> ##[1:2] !hfOscRun) else $error("oscillator kept running when disabled");
  a_tick_needs_run: assert property (sysClockEnable |-> hfOscRun)
    else $error("clock tick without running oscillator");
  a_ready_needs_run: assert property (
    $past(busReq.read) && $past(busReq.addr) == ADDR_CONTROL && readData[BIT_READY]
    |-> $past(hfOscRun)) else $error("ready read while stopped");
  a_div8_spacing: assert property (
    sysClockEnable && ctrlDivider == DIV_8 |=> !sysClockEnable [*7])
    else $error("divide by eight tick too early");
  a_trim_stable: assert property (!busReq.write |=> $stable(hfOscPeriodTrim))
    else $error("trim changed without write");
  a_clksel_stable: assert property (!busReq.write |=> $stable(clockSel))
    else $error("clock select changed without write");
  a_clksel_write: assert property (
    busReq.write && busReq.addr == ADDR_CLKSEL |=> clockSel == $past(busReq.wdata[5:0]))
    else $error("clock select not stored");
endmodule
bind hf_oscillator_clock_control hf_osc_props u_props (.core_clk(core_clk), .rst(rst),
  .busReq(busReq), .readData(readData), .hfOscRun(hfOscRun),
  .hfOscPeriodTrim(hfOscPeriodTrim), .clockSel(clockSel), .sysClockEnable(sysClockEnable));

// [tb/test_hf_oscillator_clock_control.sv]
`timescale 1ns/10ps
module test_hf_oscillator_clock_control
  import hf_osc_pkg::*;
;
  logic          core_clk, rst, usbNonIdleEvent, usbTransceiverEnable;
  logic          busPowerLevel, busPowerPolarity, hfOscRun, sysClockEnable, irq;
  bus_req_type   busReq;
  logic [7:0]    readData;
  logic [4:0]    hfOscPeriodTrim;
  clock_sel_type clockSel;
  int            fail_count = 0;
  int            num_checks = 0;

  hf_oscillator_clock_control dut (.core_clk(core_clk), .rst(rst), .busReq(busReq),
    .readData(readData), .usbNonIdleEvent(usbNonIdleEvent),
    .usbTransceiverEnable(usbTransceiverEnable), .busPowerLevel(busPowerLevel),
    .bus_power_polarity_select(busPowerPolarity), .hfOscRun(hfOscRun),
    .hfOscPeriodTrim(hfOscPeriodTrim), .clockSel(clockSel),
    .sysClockEnable(sysClockEnable), .irq(irq));

  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk); busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk); busReq <= '0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp, input string n);
    @(posedge core_clk); busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk); busReq <= '0;
    #1 check(n, readData, exp);
  endtask
  task waitRun(input logic e, input string n);
    int c;
    c = 0;
    #1;
    while (hfOscRun !== e && c < 5) begin @(posedge core_clk); #1; c++; end
    check(n, {7'h00, hfOscRun}, {7'h00, e});
  endtask
  // measures cycles between two system clock ticks
  task gap(input int exp, input string n);
    int c;
    c = 0;
    #1;
    while (sysClockEnable !== 1'b1 && c < 50) begin @(posedge core_clk); #1; c++; end
    c = 0;
    do begin @(posedge core_clk); #1; c++; end while (sysClockEnable !== 1'b1 && c < 50);
    check(n, 8'(c), 8'(exp));
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    rd(ADDR_CONTROL, CONTROL_RESET, "control");
    rd(ADDR_TRIM, {3'h0, TRIM_FACTORY}, "trim");
    check("trimPort", {3'h0, hfOscPeriodTrim}, {3'h0, TRIM_FACTORY});
    check("sysSource", 8'(clockSel.sysSource), 8'(SYS_HF));
    rd(8'h55, READ_ZERO, "unmapped");
  endtask
  task t_ready;
    repeat (SETTLE_CYCLES + 4) @(posedge core_clk);
    rd(ADDR_CONTROL, 8'hC0, "ready");
    gap(8, "div8");
    wr(ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge core_clk);
    #1 check("irqOn", {7'h00, irq}, 8'h01);
    wr(ADDR_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge core_clk);
    #1 check("irqOff", {7'h00, irq}, 8'h00);
  endtask
  task t_suspend;
    wr(ADDR_CONTROL, 8'hA3);
    waitRun(1'b0, "suspend");
    repeat (30) @(posedge core_clk);
    #1 check("held", {7'h00, hfOscRun}, 8'h00);
    @(posedge core_clk);
    usbTransceiverEnable <= 1'b0;
    usbNonIdleEvent <= 1'b1;
    @(posedge core_clk);
    usbNonIdleEvent <= 1'b0;
    waitRun(1'b1, "usbWake");
    gap(1, "div1");
    rd(ADDR_CONTROL, 8'hC3, "readyAgain");
    rd(ADDR_IRQ_STATUS, 8'h07, "status");
    wr(ADDR_CONTROL, 8'hA1);
    waitRun(1'b0, "suspend2");
    @(posedge core_clk);
    busPowerLevel <= 1'b1;
    waitRun(1'b1, "busWake");
    gap(4, "div4");
  endtask
  task t_clksel;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {2'b00, 2'(i), 2'(i % 3), 2'(3 - i)};
      wr(ADDR_CLKSEL, d);
      #1 check("clockSel", {2'b00, clockSel}, d);
    end
    wr(8'h55, 8'hFF);
    #1 check("refused", {2'b00, clockSel}, d);
    wr(ADDR_TRIM, 8'h0B);
    #1 check("trimPort2", {3'h0, hfOscPeriodTrim}, 8'h0B);
    wr(ADDR_CONTROL, 8'h82);
    gap(2, "div2");
    wr(ADDR_CONTROL, CONTROL_RESET);
    gap(8, "div8b");
    wr(ADDR_CONTROL, 8'h00);
    waitRun(1'b0, "disable");
    rd(ADDR_CONTROL, 8'h00, "off");
  endtask

  task stop_test;
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    fail_count++;
    stop_test;
  end
  initial begin
    rst = 1'b1;
    busReq = '0;
    usbNonIdleEvent = 1'b0;
    usbTransceiverEnable = 1'b1;
    busPowerLevel = 1'b0;
    busPowerPolarity = 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_ready;
    t_suspend;
    t_clksel;
    stop_test;
  end
endmodule
